// *** rtl/bptab_pkg.sv ***
// Package for the bit processor and table access execution unit
package bptab_pkg;
  // Operation codes presented by the decoder front end
  typedef enum logic [4:0] {
    BPT_NOP,
    BPT_XRD_IND,   // external_data_move read, 8-bit pointer
    BPT_XWR_IND,   // external_data_move write, 8-bit pointer
    BPT_XRD_DP,    // external_data_move read, data_pointer_16
    BPT_XWR_DP,    // external_data_move write, data_pointer_16
    BPT_CRD_DP,    // code_constant_read at A + data_pointer_16
    BPT_CRD_PC,    // code_constant_read at A + PC
    BPT_MOV_C_BIT,
    BPT_MOV_BIT_C,
    BPT_CLR_C,
    BPT_SET_C,
    BPT_CPL_C,
    BPT_CLR_BIT,
    BPT_SET_BIT,
    BPT_CPL_BIT,
    BPT_AND_C,
    BPT_ANDN_C,
    BPT_OR_C,
    BPT_ORN_C,
    BPT_JC,
    BPT_JNC,
    BPT_JB,
    BPT_JNB,
    BPT_JBC
  } bptab_op_t;

  typedef struct packed {
    bptab_op_t  op;
    logic       ptr_sel;   // 0 selects R0, 1 selects R1
    logic [7:0] bit_addr;
    logic [7:0] rel;
  } bptab_cmd_t;

  localparam logic [7:0]  BPTAB_SFR_BASE    = 8'h80;
  localparam logic [2:0]  BPTAB_CY_POS      = 3'h7;
  localparam logic [7:0]  BPTAB_ACC_RST     = 8'h00;
  localparam logic [7:0]  BPTAB_PSW_RST     = 8'h00;
  localparam logic [15:0] BPTAB_DATA_POINTER_16_RST    = 16'h0000;
  localparam logic [15:0] BPTAB_PC_RST      = 16'h0000;
  localparam logic [7:0]  BPTAB_RAM_BITBASE = 8'h20;
  // Bit address of carry: PROGRAM_STATUS_WORD at D0h, bit 7
  localparam logic [7:0]  BPTAB_CY_BITADDR  = 8'hD7;
  localparam logic [4:0]  BPTAB_PSW_SFR     = 5'h1A;
  localparam logic [4:0]  BPTAB_ACC_SFR     = 5'h1C;
  localparam logic [4:0]  BPTAB_P1_SFR      = 5'h12;
  localparam int          BPTAB_XFER_CYC    = 2;
endpackage

// *** rtl/bptab_core.sv ***
// Execution unit for external data moves, code table reads and single-bit operations
// Function
// - External data reached only indirectly: R0/R1 8-bit pointer or 16-bit data pointer
// - Accumulator is sole source or destination of every external data transfer
// - 8-bit pointer transfer supports read into and write from accumulator
// - 16-bit pointer transfer supports read into and write from accumulator
// - Data-pointer table read loads program byte at pointer plus unsigned accumulator
// - PC table read adds accumulator to PC already pointing at next instruction
// - Table reads only read program memory, never write it
// - 128 addressable bits in RAM page plus up to 128 register-space bits
// - Bit addresses 00h-7Fh map to RAM, 80h-FFh to register-space bits
// - Single-bit operands always come from a direct bit address in the instruction
// - Every port line is individually bit addressable as its own port
// - Moving carry to a port bit drives that line to the carry value
// - Carry is the bit accumulator, with own encodings and its own bit address
// - All status word bits including parity are directly bit addressable
// - Move, set, clear, complement, and AND/OR of bit or inverse into carry
// - No exclusive-OR between carry and bit is provided
// - Bit-test jumps branch when condition holds, else fall through
// - Test-and-clear jump branches on one and clears the bit in one operation
// - Relative offset is signed and added to PC only when jump taken
// - Jump span is -128 to +127 from the byte after the instruction
// - External transfers take two machine cycles, no fetch in the second
`timescale 1ns/100ps
module bptab_core #(
  parameter int PORT_W = 8
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 cmd_valid_in,
  input  wire bptab_pkg::bptab_cmd_t cmd_in,
  input  wire logic [15:0]          next_pc_in,
  input  wire logic [7:0]           ptr_r0_in,
  input  wire logic [7:0]           ptr_r1_in,
  input  wire logic [15:0]          data_pointer_16_in,
  input  wire logic [7:0]           xdata_rdata_in,
  input  wire logic [7:0]           code_rdata_in,
  input  wire logic [PORT_W-1:0]    port_pin_in,
  output logic                      cmd_ready_out,
  output logic                      done_out,
  output logic [15:0]               pc_out,
  output logic                      jump_taken_out,
  output logic [7:0]                acc_out,
  output logic [7:0]                program_status_word_out,
  output logic [15:0]               xdata_addr_out,
  output logic [7:0]                xdata_wdata_out,
  output logic                      xdata_rd_out,
  output logic                      xdata_wr_out,
  output logic [15:0]               code_addr_out,
  output logic                      code_rd_out,
  output logic                      fetch_en_out,
  output logic [PORT_W-1:0]         port_out
);
  typedef enum logic [1:0] {BPT_IDLE, BPT_XFER2, BPT_CODE2} bptab_state_t;

  bptab_state_t      state_r;
  bptab_pkg::bptab_cmd_t cmd_r;
  logic [7:0]        acc_r;
  logic [7:0]        psw_r;
  logic [127:0]      ram_bits_r;
  logic [PORT_W-1:0] port_r;
  logic [15:0]       pc_r;
  logic              done_r;
  logic              jump_r;
  logic [15:0]       xaddr_r;
  logic [7:0]        xwdata_r;
  logic              xrd_r;
  logic              xwr_r;
  logic [15:0]       caddr_r;
  logic              crd_r;
  logic              fetch_r;
  logic              ready_r;

  logic              take;
  logic [7:0]        ba;
  logic              bit_val;
  logic              cy;
  logic              bit_wr;
  logic              bit_new;
  logic              cy_wr;
  logic              cy_new;
  logic              jmp;
  logic [15:0]       rel_target;
  logic [7:0]        psw_par;

  assign take = cmd_valid_in && (state_r == BPT_IDLE);
  assign ba   = cmd_in.bit_addr;
  assign cy   = psw_r[bptab_pkg::BPTAB_CY_POS];

  // Bit read from direct address; RAM below 80h, register bits above
  always_comb begin
    bit_val = 1'b0;
    if (ba < bptab_pkg::BPTAB_SFR_BASE) begin
      bit_val = ram_bits_r[ba[6:0]];
    end else if (ba[7:3] == bptab_pkg::BPTAB_PSW_SFR) begin
      bit_val = psw_r[ba[2:0]];
    end else if (ba[7:3] == bptab_pkg::BPTAB_ACC_SFR) begin
      bit_val = acc_r[ba[2:0]];
    end else if (ba[7:3] == bptab_pkg::BPTAB_P1_SFR && ba[2:0] < PORT_W) begin
      bit_val = port_pin_in[ba[2:0]];
    end
  end

  // Bit operation decode; no exclusive-OR form exists in the op set
  always_comb begin
    bit_wr = 1'b0;
    bit_new = 1'b0;
    cy_wr = 1'b0;
    cy_new = cy;
    jmp = 1'b0;
    case (cmd_in.op)
      bptab_pkg::BPT_MOV_C_BIT: begin
        cy_wr = 1'b1;
        cy_new = bit_val;
      end
      bptab_pkg::BPT_MOV_BIT_C: begin
        bit_wr = 1'b1;
        bit_new = cy;
      end
      bptab_pkg::BPT_CLR_C: begin
        cy_wr = 1'b1;
        cy_new = 1'b0;
      end
      bptab_pkg::BPT_SET_C: begin
        cy_wr = 1'b1;
        cy_new = 1'b1;
      end
      bptab_pkg::BPT_CPL_C: begin
        cy_wr = 1'b1;
        cy_new = ~cy;
      end
      bptab_pkg::BPT_CLR_BIT: begin
        bit_wr = 1'b1;
        bit_new = 1'b0;
      end
      bptab_pkg::BPT_SET_BIT: begin
        bit_wr = 1'b1;
        bit_new = 1'b1;
      end
      bptab_pkg::BPT_CPL_BIT: begin
        bit_wr = 1'b1;
        bit_new = ~bit_val;
      end
      bptab_pkg::BPT_AND_C: begin
        cy_wr = 1'b1;
        cy_new = cy & bit_val;
      end
      bptab_pkg::BPT_ANDN_C: begin
        cy_wr = 1'b1;
        cy_new = cy & ~bit_val;
      end
      bptab_pkg::BPT_OR_C: begin
        cy_wr = 1'b1;
        cy_new = cy | bit_val;
      end
      bptab_pkg::BPT_ORN_C: begin
        cy_wr = 1'b1;
        cy_new = cy | ~bit_val;
      end
      bptab_pkg::BPT_JC:  jmp = cy;
      bptab_pkg::BPT_JNC: jmp = ~cy;
      bptab_pkg::BPT_JB:  jmp = bit_val;
      bptab_pkg::BPT_JNB: jmp = ~bit_val;
      bptab_pkg::BPT_JBC: begin
        jmp = bit_val;
        bit_wr = bit_val;
        bit_new = 1'b0;
      end
      default: begin
        jmp = 1'b0;
      end
    endcase
  end

  // Signed offset from the byte after the jump gives -128..+127 reach
  assign rel_target = next_pc_in + {{8{cmd_in.rel[7]}}, cmd_in.rel};

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= BPT_IDLE;
      cmd_r <= '0;
    end else begin
      case (state_r)
        BPT_IDLE: begin
          if (take) begin
            cmd_r <= cmd_in;
            case (cmd_in.op)
              bptab_pkg::BPT_XRD_IND, bptab_pkg::BPT_XWR_IND,
              bptab_pkg::BPT_XRD_DP, bptab_pkg::BPT_XWR_DP: state_r <= BPT_XFER2;
              bptab_pkg::BPT_CRD_DP, bptab_pkg::BPT_CRD_PC: state_r <= BPT_CODE2;
              default: state_r <= BPT_IDLE;
            endcase
          end
        end
        BPT_XFER2: state_r <= BPT_IDLE;
        BPT_CODE2: state_r <= BPT_IDLE;
        default:   state_r <= BPT_IDLE;
      endcase
    end
  end

  // Registered ready; drops for the slot after a two-cycle op is taken
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_r <= 1'b1;
    end else if (take) begin
      ready_r <= !(cmd_in.op inside {bptab_pkg::BPT_XRD_IND, bptab_pkg::BPT_XWR_IND,
                  bptab_pkg::BPT_XRD_DP, bptab_pkg::BPT_XWR_DP,
                  bptab_pkg::BPT_CRD_DP, bptab_pkg::BPT_CRD_PC});
    end else begin
      ready_r <= 1'b1;
    end
  end

  // External data strobes; address only ever from R0/R1 or the data pointer
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xaddr_r <= 16'h0000;
      xwdata_r <= 8'h00;
      xrd_r <= 1'b0;
      xwr_r <= 1'b0;
      fetch_r <= 1'b1;
    end else begin
      xrd_r <= 1'b0;
      xwr_r <= 1'b0;
      fetch_r <= 1'b1;
      if (take) begin
        case (cmd_in.op)
          bptab_pkg::BPT_XRD_IND, bptab_pkg::BPT_XWR_IND: begin
            xaddr_r <= {8'h00, cmd_in.ptr_sel ? ptr_r1_in : ptr_r0_in};
            xrd_r <= (cmd_in.op == bptab_pkg::BPT_XRD_IND);
            xwr_r <= (cmd_in.op == bptab_pkg::BPT_XWR_IND);
            xwdata_r <= acc_r;
            fetch_r <= 1'b0;
          end
          bptab_pkg::BPT_XRD_DP, bptab_pkg::BPT_XWR_DP: begin
            xaddr_r <= data_pointer_16_in;
            xrd_r <= (cmd_in.op == bptab_pkg::BPT_XRD_DP);
            xwr_r <= (cmd_in.op == bptab_pkg::BPT_XWR_DP);
            xwdata_r <= acc_r;
            fetch_r <= 1'b0;
          end
          default: begin
            fetch_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // Code port is read-only: no write strobe exists on it
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      caddr_r <= 16'h0000;
      crd_r <= 1'b0;
    end else begin
      crd_r <= 1'b0;
      if (take && cmd_in.op == bptab_pkg::BPT_CRD_DP) begin
        caddr_r <= data_pointer_16_in + {8'h00, acc_r};
        crd_r <= 1'b1;
      end else if (take && cmd_in.op == bptab_pkg::BPT_CRD_PC) begin
        caddr_r <= next_pc_in + {8'h00, acc_r};
        crd_r <= 1'b1;
      end
    end
  end

  // Accumulator: loaded by external reads and table reads, single bits by bit writes to ACC
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_r <= bptab_pkg::BPTAB_ACC_RST;
    end else if (state_r == BPT_XFER2 && (cmd_r.op == bptab_pkg::BPT_XRD_IND ||
                                           cmd_r.op == bptab_pkg::BPT_XRD_DP)) begin
      acc_r <= xdata_rdata_in;
    end else if (state_r == BPT_CODE2) begin
      acc_r <= code_rdata_in;
    end else if (take && bit_wr && ba[7:3] == bptab_pkg::BPTAB_ACC_SFR) begin
      acc_r[ba[2:0]] <= bit_new;
    end
  end

  // Status word; parity follows the accumulator
  assign psw_par = {psw_r[7:1], ^acc_r};
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      psw_r <= bptab_pkg::BPTAB_PSW_RST;
    end else if (take && bit_wr && ba[7:3] == bptab_pkg::BPTAB_PSW_SFR) begin
      psw_r <= psw_par;
      psw_r[ba[2:0]] <= bit_new;
    end else if (take && cy_wr) begin
      psw_r <= psw_par;
      psw_r[bptab_pkg::BPTAB_CY_POS] <= cy_new;
    end else begin
      psw_r <= psw_par;
    end
  end

  // Per-bit RAM flags and port latches
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++) begin : g_ram
      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          ram_bits_r[gi] <= 1'b0;
        end else if (take && bit_wr && ba == 8'(gi)) begin
          ram_bits_r[gi] <= bit_new;
        end
      end
    end
    for (gi = 0; gi < PORT_W; gi++) begin : g_port
      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          port_r[gi] <= 1'b1;
        end else if (take && bit_wr && ba == {bptab_pkg::BPTAB_P1_SFR, 3'(gi)}) begin
          port_r[gi] <= bit_new;
        end
      end
    end
  endgenerate

  // Program counter and completion
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_r <= bptab_pkg::BPTAB_PC_RST;
      done_r <= 1'b0;
      jump_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      jump_r <= 1'b0;
      if (take && state_r == BPT_IDLE) begin
        done_r <= !(cmd_in.op inside {bptab_pkg::BPT_XRD_IND, bptab_pkg::BPT_XWR_IND,
                    bptab_pkg::BPT_XRD_DP, bptab_pkg::BPT_XWR_DP,
                    bptab_pkg::BPT_CRD_DP, bptab_pkg::BPT_CRD_PC});
        jump_r <= jmp;
        pc_r <= jmp ? rel_target : next_pc_in;
      end else if (state_r != BPT_IDLE) begin
        done_r <= 1'b1;
      end
    end
  end

  assign cmd_ready_out           = ready_r;
  assign done_out                = done_r;
  assign pc_out                  = pc_r;
  assign jump_taken_out          = jump_r;
  assign acc_out                 = acc_r;
  assign program_status_word_out = psw_r;
  assign xdata_addr_out          = xaddr_r;
  assign xdata_wdata_out         = xwdata_r;
  assign xdata_rd_out            = xrd_r;
  assign xdata_wr_out            = xwr_r;
  assign code_addr_out           = caddr_r;
  assign code_rd_out             = crd_r;
  assign fetch_en_out            = fetch_r;
  assign port_out                = port_r;
endmodule

// *** bench/bptab_monitor.sv ***
// Concurrent checks on the ports of the execution unit
`timescale 1ns/100ps
module bptab_monitor (
  input wire logic                  ref_clk_in,
  input wire logic                  resetn_in,
  input wire logic                  cmd_valid_in,
  input wire bptab_pkg::bptab_cmd_t cmd_in,
  input wire logic [15:0]           next_pc_in,
  input wire logic [7:0]            ptr_r0_in,
  input wire logic [7:0]            ptr_r1_in,
  input wire logic [15:0]           data_pointer_16_in,
  input wire logic [7:0]            xdata_rdata_in,
  input wire logic [7:0]            code_rdata_in,
  input wire logic                  cmd_ready_out,
  input wire logic                  done_out,
  input wire logic [15:0]           pc_out,
  input wire logic                  jump_taken_out,
  input wire logic [7:0]            acc_out,
  input wire logic [15:0]           xdata_addr_out,
  input wire logic                  xdata_rd_out,
  input wire logic                  xdata_wr_out,
  input wire logic [15:0]           code_addr_out,
  input wire logic                  code_rd_out,
  input wire logic                  fetch_en_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  logic        take, ind, dpm, tab, jmp;
  logic [15:0] tbase, sext;
  assign take = cmd_valid_in & cmd_ready_out;
  assign ind = take && cmd_in.op inside {bptab_pkg::BPT_XRD_IND, bptab_pkg::BPT_XWR_IND};
  assign dpm = take && cmd_in.op inside {bptab_pkg::BPT_XRD_DP, bptab_pkg::BPT_XWR_DP};
  assign tab = take && cmd_in.op inside {bptab_pkg::BPT_CRD_DP, bptab_pkg::BPT_CRD_PC};
  assign jmp = take && cmd_in.op inside {[bptab_pkg::BPT_JC:bptab_pkg::BPT_JBC]};
  assign tbase = (cmd_in.op == bptab_pkg::BPT_CRD_DP) ? data_pointer_16_in : next_pc_in;
  assign sext = {{8{cmd_in.rel[7]}}, cmd_in.rel};
  chk_move_nofetch: assert property ((xdata_rd_out | xdata_wr_out) |-> !fetch_en_out)
    else $error("fetch during external move");
  chk_move_done: assert property ((xdata_rd_out | xdata_wr_out | code_rd_out) |=> done_out)
    else $error("two-cycle op not done");
  chk_ready_busy: assert property ((xdata_rd_out | xdata_wr_out | code_rd_out) |->
    !cmd_ready_out) else $error("command taken during two-cycle op");
  chk_xread_acc: assert property (xdata_rd_out |=> acc_out == $past(xdata_rdata_in))
    else $error("external byte not in acc");
  chk_table_acc: assert property (code_rd_out |=> acc_out == $past(code_rdata_in))
    else $error("table byte not in acc");
  chk_ptr_addr: assert property (ind |=> (xdata_rd_out | xdata_wr_out) &&
    xdata_addr_out == {8'h00, $past(cmd_in.ptr_sel) ? $past(ptr_r1_in) : $past(ptr_r0_in)})
    else $error("8-bit pointer address wrong");
  chk_data_pointer_16_addr: assert property (dpm |=> (xdata_rd_out | xdata_wr_out) &&
    xdata_addr_out == $past(data_pointer_16_in)) else $error("data pointer address wrong");
  chk_table_addr: assert property (tab |=> code_rd_out &&
    code_addr_out == $past(tbase) + {8'h00, $past(acc_out)}) else $error("table address wrong");
  chk_rel_target: assert property (jmp |=> done_out &&
    pc_out == $past(next_pc_in) + (jump_taken_out ? $past(sext) : 16'h0000))
    else $error("jump target wrong");
endmodule

// *** bench/bptab_mem_model.sv ***
// External data memory and read-only program memory seen by the unit
`timescale 1ns/100ps
module bptab_mem_model (
  input  wire logic        ref_clk_in,
  input  wire logic [15:0] xaddr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] caddr_in,
  input  wire logic        crd_in,
  output logic [7:0]       rdata_out,
  output logic [7:0]       cdata_out
);
  logic [7:0] mem_r [0:65535];
  logic [7:0] cbyte;
  assign cbyte = caddr_in[15:8] ^ caddr_in[7:0] ^ 8'hA5;
  // Idle lines carry the inverse, so a sample in the wrong cycle shows up
  assign rdata_out = rd_in ? mem_r[xaddr_in] : ~mem_r[xaddr_in];
  assign cdata_out = crd_in ? cbyte : ~cbyte;
  always_ff @(posedge ref_clk_in) begin
    if (wr_in) begin
      mem_r[xaddr_in] <= wdata_in;
    end
  end
endmodule

// *** bench/bptab_core_tb.sv ***
// Random and corner-case bench for the execution unit
`timescale 1ns/100ps
module bptab_core_tb;
  logic                  ref_clk_in = 1'b0, resetn_in = 1'b0, cmd_valid_in = 1'b0, psel = 1'b0;
  bptab_pkg::bptab_cmd_t cmd_in = '0;
  logic [15:0]           next_pc_in = '0, data_pointer_16_in = '0, s_np = '0, s_dp = '0, a;
  logic [7:0]            ptr_r0_in = '0, ptr_r1_in = '0, port_pin_in = '0, s_r0 = '0, s_r1 = '0;
  logic [7:0]            s_pin = '0, bit_a, av, rl, xdata_rdata_in, code_rdata_in, acc_out;
  logic [7:0]            program_status_word_out, xdata_wdata_out, port_out;
  logic [15:0]           pc_out, xdata_addr_out, code_addr_out;
  logic                  cmd_ready_out, done_out, jump_taken_out, xdata_rd_out, xdata_wr_out;
  logic                  code_rd_out, fetch_en_out, c, b, e, cy;
  int                    err_count = 0, n_tests = 0;
  assign cy = program_status_word_out[7];
  bptab_core uut (.ref_clk_in, .resetn_in, .cmd_valid_in, .cmd_in, .next_pc_in, .ptr_r0_in,
    .ptr_r1_in, .data_pointer_16_in, .xdata_rdata_in, .code_rdata_in, .port_pin_in,
    .cmd_ready_out, .done_out, .pc_out, .jump_taken_out, .acc_out, .program_status_word_out,
    .xdata_addr_out, .xdata_wdata_out, .xdata_rd_out, .xdata_wr_out, .code_addr_out,
    .code_rd_out, .fetch_en_out, .port_out);
  bptab_mem_model mem (.ref_clk_in, .xaddr_in(xdata_addr_out), .wdata_in(xdata_wdata_out),
    .rd_in(xdata_rd_out), .wr_in(xdata_wr_out), .caddr_in(code_addr_out),
    .crd_in(code_rd_out), .rdata_out(xdata_rdata_in), .cdata_out(code_rdata_in));
  function automatic logic [7:0] cb(input logic [15:0] x);
    return x[15:8] ^ x[7:0] ^ 8'hA5;
  endfunction
  function automatic logic lexp(input logic [3:0] k);
    logic t;
    t = k[2] ? ~k[0] : k[0];
    return k[3] ? (k[1] | t) : (k[1] & t);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Operands change with the command so they are stable at the taking edge
  always @(posedge ref_clk_in) begin
    ptr_r0_in <= s_r0;
    ptr_r1_in <= s_r1;
    data_pointer_16_in <= s_dp;
    next_pc_in <= s_np;
    port_pin_in <= s_pin;
  end
  task automatic run(input bptab_pkg::bptab_op_t op, input logic [7:0] ba, input logic [7:0] r);
    int n;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= '{op, psel, ba, r};
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (done_out !== 1'b1 && n < 8);
    chk(16'(done_out), 16'h0001);
  endtask
  task automatic load_acc(input logic [15:0] x);
    s_dp = x - {8'h00, acc_out};
    run(bptab_pkg::BPT_CRD_DP, 8'h00, 8'h00);
    chk(16'(acc_out), 16'(cb(x)));
  endtask
  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #20_000;
    err_count++;
    finish_test();
  end
  initial begin
    void'($urandom(56));
    repeat (20) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(negedge ref_clk_in);
    chk({program_status_word_out, port_out}, 16'h00FF);
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom);
      load_acc(a);
      psel = i[2];
      s_r0 = psel ? ~a[7:0] : a[7:0];
      s_r1 = psel ? a[7:0] : ~a[7:0];
      s_dp = {8'h00, a[7:0]};
      run(i[0] ? bptab_pkg::BPT_XWR_DP : bptab_pkg::BPT_XWR_IND, 8'h00, 8'h00);
      load_acc(a ^ 16'h0100);
      s_dp = {8'h00, a[7:0]};
      run(i[1] ? bptab_pkg::BPT_XRD_DP : bptab_pkg::BPT_XRD_IND, 8'h00, 8'h00);
      chk(16'(acc_out), 16'(cb(a)));
    end
    // First pass leaves entry zero, which must return the byte at the next pc
    for (int i = 0; i < 4; i++) begin
      load_acc(i == 0 ? 16'h00A5 : 16'($urandom));
      s_np = 16'($urandom);
      av = acc_out;
      run(bptab_pkg::BPT_CRD_PC, 8'h00, 8'h00);
      chk(16'(acc_out), 16'(cb(s_np + {8'h00, av})));
    end
    for (int k = 0; k < 5; k++) begin
      run(k == 4 ? bptab_pkg::BPT_SET_BIT : k == 3 ? bptab_pkg::BPT_CLR_C :
          k == 0 ? bptab_pkg::BPT_SET_C : bptab_pkg::BPT_CPL_C, bptab_pkg::BPTAB_CY_BITADDR, 8'h00);
      chk(16'(cy), 16'(!k[0]));
    end
    for (int k = 0; k < 16; k++) begin
      bit_a = 8'($urandom);
      bit_a = bit_a[7] ? {5'b11100, bit_a[2:0]} : bit_a;
      run(k[1] ? bptab_pkg::BPT_SET_C : bptab_pkg::BPT_CLR_C, 8'h00, 8'h00);
      run(k[0] ? bptab_pkg::BPT_SET_BIT : bptab_pkg::BPT_CLR_BIT, bit_a, 8'h00);
      run(bptab_pkg::bptab_op_t'(bptab_pkg::BPT_AND_C + k[3:2]), bit_a, 8'h00);
      chk(16'(cy), 16'(lexp(k[3:0])));
    end
    for (int k = 0; k < 10; k++) begin
      bit_a = {1'b0, 7'($urandom)};
      b = k[0];
      rl = b ? 8'h80 : 8'h7F;
      s_np = 16'($urandom);
      run(b ? bptab_pkg::BPT_SET_C : bptab_pkg::BPT_CLR_C, 8'h00, 8'h00);
      run(b ? bptab_pkg::BPT_SET_BIT : bptab_pkg::BPT_CLR_BIT, bit_a, 8'h00);
      run(bptab_pkg::bptab_op_t'(bptab_pkg::BPT_JC + k / 2), bit_a, rl);
      e = b ^ (k / 2 == 1 || k / 2 == 3);
      chk(16'(jump_taken_out), 16'(e));
      chk(pc_out, s_np + (e ? {{8{rl[7]}}, rl} : 16'h0000));
      run(bptab_pkg::BPT_MOV_C_BIT, bit_a, 8'h00);
      chk(16'(cy), 16'(b && k / 2 != 4));
    end
    for (int i = 0; i < 8; i++) begin
      c = 1'($urandom);
      s_pin = 8'($urandom);
      run(c ? bptab_pkg::BPT_SET_C : bptab_pkg::BPT_CLR_C, 8'h00, 8'h00);
      run(bptab_pkg::BPT_MOV_BIT_C, 8'h90 + 8'(i), 8'h00);
      chk(16'(port_out[i]), 16'(c));
      run(bptab_pkg::BPT_MOV_BIT_C, 8'h70 + 8'(i), 8'h00);
      run(bptab_pkg::BPT_CPL_BIT, 8'h70 + 8'(i), 8'h00);
      run(bptab_pkg::BPT_MOV_C_BIT, 8'h70 + 8'(i), 8'h00);
      chk(16'(cy), 16'(!c));
      run(bptab_pkg::BPT_MOV_C_BIT, 8'h90 + 8'(i), 8'h00);
      chk(16'(cy), 16'(s_pin[i]));
      load_acc(16'($urandom));
      run(bptab_pkg::BPT_JB, 8'hD0, 8'h00);
      chk(16'(jump_taken_out), 16'(^acc_out));
    end
    finish_test();
  end
endmodule
bind bptab_core bptab_monitor mon (.ref_clk_in, .resetn_in, .cmd_valid_in, .cmd_in, .next_pc_in,
  .ptr_r0_in, .ptr_r1_in, .data_pointer_16_in, .xdata_rdata_in, .code_rdata_in, .cmd_ready_out,
  .done_out, .pc_out, .jump_taken_out, .acc_out, .xdata_addr_out, .xdata_rd_out, .xdata_wr_out,
  .code_addr_out, .code_rd_out, .fetch_en_out);
